// file: verilog/tcu_params.svh
// Constants of the 8-bit timer/counter with one compare channel.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH
`define TCU_BOTTOM 8'h00
`define TCU_MAX 8'hFF
`define TCU_CS_STOP 3'h0
`define TCU_CS_DIV1 3'h1
`define TCU_CS_DIV8 3'h2
`define TCU_CS_DIV64 3'h3
`define TCU_CS_DIV256 3'h4
`define TCU_CS_DIV1024 3'h5
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7
`define TCU_WGM_NORMAL 2'h0
`define TCU_WGM_PHASE 2'h1
`define TCU_WGM_CTC 2'h2
`define TCU_WGM_FAST 2'h3
`define TCU_COM_NONE 2'h0
`define TCU_COM_TOGGLE 2'h1
`define TCU_COM_CLEAR 2'h2
`define TCU_COM_SET 2'h3
`define TCU_PRE_W 10
`define TCU_PRE_MASK8 10'h007
`define TCU_PRE_MASK64 10'h03F
`define TCU_PRE_MASK256 10'h0FF
`define TCU_PRE_MASK1024 10'h3FF
`define TCU_RST_BYTE 8'h00
`endif

// file: verilog/tcu_pkg.sv
// Types of the 8-bit timer/counter with one compare channel.
// Assumes the constants header is on the include path.
`include "tcu_params.svh"
package tcu_pkg;
	typedef logic [7:0] tcu_byte_t;
	typedef enum logic [1:0] {
		TCU_NORMAL = 2'b00,
		TCU_PHASE = 2'b01,
		TCU_CTC = 2'b10,
		TCU_FAST = 2'b11
	} tcu_mode_e;
	typedef struct packed {
		logic [1:0] compare_output_mode_field;
		logic [1:0] waveform_mode_field;
		logic [2:0] clock_select_field;
	} tcu_ctrl_s;
	typedef struct packed {
		logic overflow_flag;
		logic compare_match_flag;
	} tcu_flags_s;
endpackage

// file: verilog/tcu_tick_sel.sv
// Tick source selection: shared free-running prescaler taps and external input edges.
// Assumes ext_count_input is synchronous to core_clk.
`timescale 1ns/1ps
module tcu_tick_sel
	import tcu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [2:0] clock_select_field,
	input wire logic ext_count_input,
	output logic timer_tick
);
	logic [`TCU_PRE_W-1:0] pre_q;
	logic [`TCU_PRE_W-1:0] pre_d;
	logic ext_q;
	logic tick_q;
	logic tick_d;
	wire ext_rise = ext_count_input & ~ext_q;
	wire ext_fall = ~ext_count_input & ext_q;

	// ****************************************
	// Tap decode.
	// ****************************************
	function automatic logic tap_hit(input logic [2:0] cs, input logic [`TCU_PRE_W-1:0] p,
		input logic rise, input logic fall);
		case (cs)
			`TCU_CS_STOP: tap_hit = 1'b0;
			`TCU_CS_DIV1: tap_hit = 1'b1;
			`TCU_CS_DIV8: tap_hit = (p & `TCU_PRE_MASK8) == `TCU_PRE_MASK8;
			`TCU_CS_DIV64: tap_hit = (p & `TCU_PRE_MASK64) == `TCU_PRE_MASK64;
			`TCU_CS_DIV256: tap_hit = (p & `TCU_PRE_MASK256) == `TCU_PRE_MASK256;
			`TCU_CS_DIV1024: tap_hit = p == `TCU_PRE_MASK1024;
			`TCU_CS_EXT_FALL: tap_hit = fall;
			default: tap_hit = rise;
		endcase
	endfunction

	assign pre_d = pre_q + `TCU_PRE_W'(1);
	assign tick_d = tap_hit(clock_select_field, pre_q, ext_rise, ext_fall);
	assign timer_tick = tick_q;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pre_q <= '0;
			ext_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_q <= pre_d;
			ext_q <= ext_count_input;
			tick_q <= tick_d;
		end
	end
endmodule

// file: verilog/tcu_timer.sv
// 8-bit timer/counter with one compare channel, control and flags as plain ports.
// Assumes CPU strobes are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
module tcu_timer
	import tcu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ctrl_wr,
	input wire tcu_ctrl_s ctrl_wdata,
	input wire logic force_compare_strobe,
	input wire logic counter_wr,
	input wire tcu_byte_t counter_wdata,
	input wire logic compare_wr,
	input wire tcu_byte_t compare_wdata,
	input wire logic flag_wr,
	input wire tcu_flags_s flag_wdata,
	input wire logic overflow_irq_ack,
	input wire logic compare_irq_ack,
	input wire logic overflow_irq_enable,
	input wire logic compare_irq_enable,
	input wire logic global_irq_enable,
	input wire logic ext_count_input,
	output tcu_ctrl_s timer_control_reg,
	output tcu_byte_t counter_value,
	output tcu_byte_t compare_value_reg,
	output tcu_flags_s timer_flag_reg,
	output logic compare_output,
	output logic overflow_irq,
	output logic compare_irq,
	output logic at_bottom,
	output logic at_max
);
	tcu_ctrl_s ctrl_q;
	tcu_byte_t cnt_q;
	tcu_byte_t cnt_d;
	tcu_byte_t ocr_q;
	tcu_byte_t ocr_d;
	tcu_byte_t ocr_buf_q;
	tcu_byte_t ocr_buf_d;
	logic oc_q;
	logic oc_d;
	logic dir_down_q;
	logic dir_down_d;
	logic ovf_q;
	logic ovf_d;
	logic ocf_q;
	logic ocf_d;
	logic match_pend_q;
	logic block_q;
	logic block_d;
	logic bot_q;
	logic max_q;
	logic ovf_irq_q;
	logic ocf_irq_q;
	logic timer_tick;

	// ****************************************
	// Tick source.
	// ****************************************
	tcu_tick_sel u_tick
	(
		.core_clk(core_clk),
		.rstn(rstn),
		.clock_select_field(ctrl_q.clock_select_field),
		.ext_count_input(ext_count_input),
		.timer_tick(timer_tick)
	);

	// ****************************************
	// Mode decode and comparator.
	// ****************************************
	wire tcu_mode_e mode = tcu_mode_e'(ctrl_q.waveform_mode_field);
	wire is_normal = mode == TCU_NORMAL;
	wire is_ctc = mode == TCU_CTC;
	wire is_fast = mode == TCU_FAST;
	wire is_phase = mode == TCU_PHASE;
	wire is_pwm = is_fast | is_phase;
	wire bottom = cnt_q == `TCU_BOTTOM;
	wire maxed = cnt_q == `TCU_MAX;
	wire tcu_byte_t top_val = is_ctc ? ocr_q : `TCU_MAX;
	wire at_top = cnt_q == top_val;
	wire match = cnt_q == ocr_q;
	wire match_ok = match & ~block_q;
	wire [1:0] com = ctrl_q.compare_output_mode_field;

	// The output action of a non-PWM match or a forced match.
	function automatic logic com_action(input logic [1:0] c, input logic cur);
		case (c)
			`TCU_COM_NONE: com_action = cur;
			`TCU_COM_TOGGLE: com_action = ~cur;
			`TCU_COM_CLEAR: com_action = 1'b0;
			default: com_action = 1'b1;
		endcase
	endfunction

	// ****************************************
	// Counter next value.
	// ****************************************
	always_comb
	begin
		cnt_d = cnt_q;
		dir_down_d = dir_down_q;
		if (counter_wr)
			cnt_d = counter_wdata;
		else if (timer_tick)
		begin
			if (is_ctc && at_top)
				cnt_d = `TCU_BOTTOM;
			else if (is_fast && at_top)
				cnt_d = `TCU_BOTTOM;
			else if (is_phase)
			begin
				if (maxed)
					dir_down_d = 1'b1;
				else if (bottom)
					dir_down_d = 1'b0;
				cnt_d = (dir_down_q && !maxed) || (maxed) ? cnt_q - 8'h01 : cnt_q + 8'h01;
				if (bottom)
					cnt_d = cnt_q + 8'h01;
			end
			else
				cnt_d = cnt_q + 8'h01;
		end
	end

	// ****************************************
	// Compare register and buffer.
	// ****************************************
	wire ocr_load = timer_tick & ((is_fast & maxed) | (is_phase & maxed));
	assign ocr_buf_d = (compare_wr && is_pwm) ? compare_wdata : ocr_buf_q;
	always_comb
	begin
		ocr_d = ocr_q;
		if (compare_wr && !is_pwm)
			ocr_d = compare_wdata;
		else if (ocr_load)
			ocr_d = ocr_buf_q;
	end

	// ****************************************
	// Output state.
	// ****************************************
	always_comb
	begin
		oc_d = oc_q;
		if (force_compare_strobe && !is_pwm)
			oc_d = com_action(com, oc_q);
		else if (timer_tick && !is_pwm && match_ok)
			oc_d = com_action(com, oc_q);
		else if (timer_tick && is_fast && com[1])
		begin
			if (match_ok)
				oc_d = ~com[0];
			else if (maxed)
				oc_d = com[0];
		end
		else if (timer_tick && is_phase && com[1] && match_ok)
			oc_d = dir_down_q ? com[0] : ~com[0];
	end

	// ****************************************
	// Flags and blocking.
	// ****************************************
	wire ovf_set = timer_tick & (is_pwm ? (is_fast ? maxed : bottom) : maxed);
	wire ocf_set = timer_tick & match_pend_q;
	wire ovf_clr = overflow_irq_ack | (flag_wr & flag_wdata.overflow_flag);
	wire ocf_clr = compare_irq_ack | (flag_wr & flag_wdata.compare_match_flag);
	assign ovf_d = ovf_set | (ovf_q & ~ovf_clr);
	assign ocf_d = ocf_set | (ocf_q & ~ocf_clr);
	assign block_d = counter_wr | (block_q & ~timer_tick);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q <= '0;
			cnt_q <= `TCU_RST_BYTE;
			ocr_q <= `TCU_RST_BYTE;
			ocr_buf_q <= `TCU_RST_BYTE;
			oc_q <= 1'b0;
			dir_down_q <= 1'b0;
			ovf_q <= 1'b0;
			ocf_q <= 1'b0;
			match_pend_q <= 1'b0;
			block_q <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_q <= ctrl_wdata;
			cnt_q <= cnt_d;
			ocr_q <= ocr_d;
			ocr_buf_q <= ocr_buf_d;
			oc_q <= oc_d;
			dir_down_q <= dir_down_d;
			ovf_q <= ovf_d;
			ocf_q <= ocf_d;
			if (timer_tick)
				match_pend_q <= match_ok;
			block_q <= block_d;
		end
	end

	// ****************************************
	// Registered status and requests.
	// ****************************************
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bot_q <= 1'b0;
			max_q <= 1'b0;
			ovf_irq_q <= 1'b0;
			ocf_irq_q <= 1'b0;
		end
		else
		begin
			bot_q <= cnt_d == `TCU_BOTTOM;
			max_q <= cnt_d == `TCU_MAX;
			ovf_irq_q <= ovf_d & overflow_irq_enable & global_irq_enable;
			ocf_irq_q <= ocf_d & compare_irq_enable & global_irq_enable;
		end
	end

	assign timer_control_reg = ctrl_q;
	assign counter_value = cnt_q;
	assign compare_value_reg = is_pwm ? ocr_buf_q : ocr_q;
	assign timer_flag_reg = {ovf_q, ocf_q};
	assign compare_output = oc_q;
	assign overflow_irq = ovf_irq_q;
	assign compare_irq = ocf_irq_q;
	assign at_bottom = bot_q;
	assign at_max = max_q;
endmodule

// file: verification/tcu_timer_properties.sv
// Concurrent checks on the timer ports.
// Assumes it is bound into every tcu_timer instance.
`timescale 1ns/1ps
module tcu_timer_checker
	import tcu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic counter_wr,
	input wire tcu_byte_t counter_wdata,
	input wire logic compare_wr,
	input wire logic compare_irq_ack,
	input wire logic compare_irq_enable,
	input wire logic global_irq_enable,
	input wire logic force_compare_strobe,
	input wire tcu_ctrl_s timer_control_reg,
	input wire tcu_byte_t counter_value,
	input wire tcu_byte_t compare_value_reg,
	input wire tcu_flags_s timer_flag_reg,
	input wire logic compare_output,
	input wire logic compare_irq,
	input wire logic at_bottom
);
// ****
// Properties
// ****
default clocking @(posedge core_clk);
endclocking
default disable iff (!rstn);
wire logic stop = timer_control_reg.clock_select_field == 3'h0;
wire logic [1:0] wgm = timer_control_reg.waveform_mode_field;
wire tcu_byte_t cv = counter_value;
property p_bottom;
	cv == 8'h00 ##1 cv == 8'h00 |-> at_bottom;
endproperty
a_bottom: assert property (p_bottom) else $error("bottom low");
property p_stop;
	stop ##1 (stop && !counter_wr) |=> $stable(cv);
endproperty
a_stop: assert property (p_stop) else $error("count while stopped");
property p_wr;
	counter_wr |=> cv == $past(counter_wdata);
endproperty
a_wr: assert property (p_wr) else $error("counter write lost");
property p_irq;
	compare_irq |-> timer_flag_reg.compare_match_flag && $past(compare_irq_enable && global_irq_enable);
endproperty
a_irq: assert property (p_irq) else $error("irq unqualified");
property p_ack;
	stop ##1 (stop && compare_irq_ack) |=> !timer_flag_reg.compare_match_flag;
endproperty
a_ack: assert property (p_ack) else $error("flag kept after ack");
sequence s_wrap;
	wgm == 2'h0 && cv == 8'hFF && !counter_wr ##1 cv == 8'h00;
endsequence
property p_ovf;
	s_wrap |-> timer_flag_reg.overflow_flag;
endproperty
a_ovf: assert property (p_ovf) else $error("no overflow flag");
sequence s_hit;
	wgm == 2'h2 && cv == compare_value_reg - 8'h01 && !counter_wr
	##1 wgm == 2'h2 && cv == compare_value_reg && !counter_wr && !compare_wr;
endsequence
property p_ctc;
	s_hit ##1 cv != $past(cv) |-> cv == 8'h00;
endproperty
a_ctc: assert property (p_ctc) else $error("no clear at top");
property p_force;
	force_compare_strobe && wgm == 2'h0 && timer_control_reg.compare_output_mode_field == 2'h1
	|=> compare_output != $past(compare_output);
endproperty
a_force: assert property (p_force) else $error("force no toggle");
endmodule
bind tcu_timer tcu_timer_checker u_chk (.*);

// file: verification/tcu_cpu_model.sv
// CPU stand-in that services the compare interrupt.
// Assumes the irq output is a registered level.
`timescale 1ns/1ps
module tcu_cpu_model
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic service_en,
	input wire logic slow,
	input wire logic compare_irq,
	output logic compare_irq_ack
);
logic [1:0] wait_q;
wire logic req = service_en && compare_irq && !compare_irq_ack;
// Slow service lets the request wait three cycles first.
always_ff @(posedge core_clk or negedge rstn)
begin
	if (!rstn)
	begin
		wait_q <= 2'h0;
		compare_irq_ack <= 1'b0;
	end
	else
	begin
		wait_q <= req ? wait_q + 2'h1 : 2'h0;
		compare_irq_ack <= req && (!slow || wait_q == 2'h3);
	end
end
endmodule

// file: verification/tcu_timer_bench.sv
// Bench of the timer: forced compare rows, then directed cases.
// Assumes the checker binds itself into the design.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: got %h want %h", $time, a, b); end end
`define WT(c) begin i = 0; while ((c) !== 1'b1) begin @(negedge core_clk); i++; if (i > 600) begin n_mismatch++; close_out; end end end
module tcu_timer_bench
	import tcu_pkg::*;
();
logic core_clk = 1'b0, rstn = 1'b0, ctrl_wr = 1'b0, force_compare_strobe = 1'b0, counter_wr = 1'b0;
logic compare_wr = 1'b0, flag_wr = 1'b0, compare_irq_enable = 1'b0, global_irq_enable = 1'b0;
logic ext_count_input = 1'b0, svc_en = 1'b0, slow = 1'b0, compare_output, compare_irq, compare_irq_ack, at_bottom, at_max;
logic ovf_irq;
tcu_ctrl_s ctrl_wdata = 7'h00, timer_control_reg;
tcu_byte_t counter_wdata = 8'h00, compare_wdata = 8'h00, counter_value, compare_value_reg, mx;
tcu_flags_s flag_wdata = 2'h0, timer_flag_reg;
int n_mismatch = 0, comparisons = 0, i, j, k, nack;
// Rows of output mode and expected output after a forced compare.
logic [2:0] rows [5] = '{3'h3, 3'h4, 3'h7, 3'h1, 3'h2};
always #2.5 core_clk = ~core_clk;
tcu_timer DUT (.overflow_irq_ack(1'b0), .overflow_irq_enable(1'b1), .overflow_irq(ovf_irq), .*);
tcu_cpu_model u_cpu (.service_en(svc_en), .*);
// ****
// Tasks
// ****
task close_out;
	$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
	if (n_mismatch == 0 && comparisons > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
task cyc(input int n);
	repeat (n) @(negedge core_clk);
endtask
// Kinds: 0 control, 1 counter, 2 compare, 3 force, 4 flag clear.
task st(input int w, input tcu_byte_t v);
	@(posedge core_clk);
	ctrl_wdata <= v[6:0];
	counter_wdata <= v;
	compare_wdata <= v;
	flag_wdata <= v[1:0];
	{flag_wr, force_compare_strobe, compare_wr, counter_wr, ctrl_wr} <= 5'(5'h01 << w);
	@(posedge core_clk);
	{flag_wr, force_compare_strobe, compare_wr, counter_wr, ctrl_wr} <= 5'h00;
	cyc(1);
endtask
task rchk;
	`CHK(counter_value, 8'h00)
	`CHK(compare_value_reg, 8'h00)
	`CHK(timer_flag_reg, 2'h0)
	`CHK(timer_control_reg, 7'h00)
	`CHK(compare_output, 1'b0)
endtask
initial
begin
	repeat (10) @(posedge core_clk);
	rstn <= 1'b1;
	cyc(1);
	rchk;
	st(1, 8'h10);
	for (j = 0; j < 5; j++)
	begin
		st(0, {1'b0, rows[j][2:1], 5'h00});
		st(3, 8'h00);
		`CHK(compare_output, rows[j][0])
		`CHK(counter_value, 8'h10)
		`CHK(timer_flag_reg, 2'h0)
	end
	st(0, 8'h28);
	st(3, 8'h00);
	`CHK(compare_output, 1'b0)
	st(2, 8'h40);
	`CHK(compare_value_reg, 8'h40)
	st(0, 8'h20);
	`CHK(compare_value_reg, 8'h00)
	st(2, 8'h20);
	st(1, 8'h20);
	st(0, 8'h21);
	cyc(5);
	`CHK(timer_flag_reg, 2'h0)
	`CHK(counter_value > 8'h20, 1'b1)
	`WT(timer_flag_reg.overflow_flag)
	`CHK(counter_value, 8'h00)
	`WT(timer_flag_reg.compare_match_flag)
	`CHK(counter_value, 8'h22)
	`CHK(compare_output, 1'b1)
	st(4, 8'h03);
	`CHK(timer_flag_reg, 2'h0)
	st(0, 8'h30);
	st(2, 8'h03);
	st(1, 8'h00);
	@(posedge core_clk);
	compare_irq_enable <= 1'b1;
	global_irq_enable <= 1'b1;
	svc_en <= 1'b1;
	st(0, 8'h31);
	mx = 8'h00;
	nack = 0;
	for (j = 0; j < 40; j++)
	begin
		@(posedge core_clk);
		slow <= j > 19;
		cyc(1);
		if (counter_value > mx)
			mx = counter_value;
		nack += compare_irq_ack;
	end
	`CHK(mx, 8'h03)
	`CHK(nack > 1, 1'b1)
	@(posedge core_clk);
	svc_en <= 1'b0;
	global_irq_enable <= 1'b0;
	`WT(timer_flag_reg.compare_match_flag)
	cyc(2);
	`CHK(compare_irq, 1'b0)
	st(0, 8'h30);
	@(posedge core_clk);
	global_irq_enable <= 1'b1;
	svc_en <= 1'b1;
	cyc(8);
	`CHK(timer_flag_reg.compare_match_flag, 1'b0)
	st(0, 8'h19);
	st(2, 8'h80);
	`WT(at_max)
	`CHK(counter_value, 8'hFF)
	`WT(at_bottom)
	`CHK(ovf_irq, 1'b1)
	st(0, 8'h00);
	`CHK(compare_value_reg, 8'h80)
	st(1, 8'h00);
	for (k = 0; k < 2; k++)
	begin
		st(0, 8'(7 - k));
		for (j = 0; j < 6; j++)
		begin
			@(posedge core_clk);
			ext_count_input <= ~ext_count_input;
			cyc(4);
		end
		`CHK(counter_value, 8'(3 * k + 3))
	end
	@(posedge core_clk);
	rstn <= 1'b0;
	cyc(2);
	rchk;
	close_out;
end
endmodule
